// [hdl/dsl_device.sv]
// Implementation choices: the placing of the registers and register access over APB.
`default_nettype none
module dsl_device (
  // clock and resets
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       power_on_reset_n,
  // command link
  dsl_link_if.dev         link,
  // state machine side
  input  wire logic [2:0] device_state,
  input  wire logic       in_reset_state,
  input  wire logic       off_reached,
  input  wire logic       reset_entry,
  input  wire logic       lbist_done,
  input  wire logic       regulator_ov,
  // monitored inputs
  input  wire logic       wake,
  input  wire logic       wake_latched,
  input  wire logic       host_err_in,
  input  wire logic       sync_clk_ok,
  input  wire logic       safe_timeout_off,
  // guards and requests
  output logic            auto_restart_block,
  output logic            config_write_guard,
  output logic            control_write_guard,
  output logic            selftest_control_guard,
  output logic            diag_timer_hold,
  output logic            start_request,
  output logic            host_reset_request
);
  logic       auto_block_q;
  logic       cfg_guard_q;
  logic       ctrl_guard_q;
  logic       bist_guard_q;
  logic       diag_hold_q;
  logic       host_rst_flag_q;
  logic       start_q;
  logic       host_rst_q;
  logic       wake_q;
  logic [2:0] prev_state_q;
  logic       rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic [7:0] rsp_data_d;
  logic [7:0] status_main;
  logic [7:0] status_secondary;
  logic       take;
  logic       in_diag;
  logic       in_run;
  logic       left_diag;
  logic       left_run;

  // commands are ignored outright while the core sits in reset
  assign take      = link.cmd_valid && !in_reset_state;
  assign in_diag   = device_state == dsl_pkg::ST_DIAG;
  assign in_run    = (device_state == dsl_pkg::ST_DIAG) ||
                     (device_state == dsl_pkg::ST_ACTIVE) ||
                     (device_state == dsl_pkg::ST_SAFE);
  assign left_diag = (prev_state_q == dsl_pkg::ST_DIAG) && !in_diag;
  assign left_run  = (prev_state_q != device_state) &&
                     ((prev_state_q == dsl_pkg::ST_DIAG) ||
                      (prev_state_q == dsl_pkg::ST_ACTIVE) ||
                      (prev_state_q == dsl_pkg::ST_SAFE));

  function automatic logic hit(input logic [7:0] code, input logic [7:0] key);
    hit = take && (link.cmd_code == code) && (link.cmd_data == key);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_state_q <= 3'h0;
    end else begin
      prev_state_q <= device_state;
    end
  end

  // of the two resets only battery loss (presetn) clears it; power_on_reset_n leaves it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_block_q <= dsl_pkg::RST_AUTO_BLOCK;
    end else if (regulator_ov) begin
      auto_block_q <= 1'b1;
    end else if (hit(dsl_pkg::CMD_BLOCK_AUTO_RESTART, dsl_pkg::KEY_AA)) begin
      auto_block_q <= 1'b1;
    end else if (hit(dsl_pkg::CMD_ALLOW_AUTO_RESTART, dsl_pkg::KEY_55)) begin
      auto_block_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_guard_q <= dsl_pkg::RST_GUARD;
    end else if (!power_on_reset_n) begin
      cfg_guard_q <= dsl_pkg::RST_GUARD;
    end else if ((hit(dsl_pkg::CMD_GUARD_CONFIG, dsl_pkg::KEY_55) && in_diag) ||
                 left_diag || lbist_done) begin
      cfg_guard_q <= 1'b1;
    end else if (hit(dsl_pkg::CMD_UNGUARD_CONFIG, dsl_pkg::KEY_AA) && in_diag) begin
      cfg_guard_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_guard_q <= dsl_pkg::RST_GUARD;
    end else if (!power_on_reset_n) begin
      ctrl_guard_q <= dsl_pkg::RST_GUARD;
    end else if ((hit(dsl_pkg::CMD_GUARD_CONTROL, dsl_pkg::KEY_55) && in_run) ||
                 left_diag || lbist_done) begin
      ctrl_guard_q <= 1'b1;
    end else if (hit(dsl_pkg::CMD_UNGUARD_CONTROL, dsl_pkg::KEY_AA) && in_run) begin
      ctrl_guard_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bist_guard_q <= dsl_pkg::RST_GUARD;
    end else if (!power_on_reset_n) begin
      bist_guard_q <= dsl_pkg::RST_GUARD;
    end else if ((hit(dsl_pkg::CMD_GUARD_CONTROL, dsl_pkg::KEY_55) && in_run) ||
                 left_run || lbist_done) begin
      bist_guard_q <= 1'b1;
    end else if (hit(dsl_pkg::CMD_UNGUARD_CONTROL, dsl_pkg::KEY_AA) && in_run) begin
      bist_guard_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_hold_q <= dsl_pkg::RST_DIAG_HOLD;
    end else if (!power_on_reset_n) begin
      diag_hold_q <= dsl_pkg::RST_DIAG_HOLD;
    end else if (hit(dsl_pkg::CMD_HOLD_DIAG_EXIT, dsl_pkg::KEY_55)) begin
      diag_hold_q <= 1'b1;
    end else if (hit(dsl_pkg::CMD_RELEASE_DIAG_EXIT, dsl_pkg::KEY_AA)) begin
      diag_hold_q <= 1'b0;
    end
  end

  // flag follows the cause of the latest reset entry; reads never touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_rst_flag_q <= dsl_pkg::RST_HOST_RST;
      host_rst_q      <= 1'b0;
    end else if (!power_on_reset_n) begin
      host_rst_flag_q <= dsl_pkg::RST_HOST_RST;
      host_rst_q      <= 1'b0;
    end else if (hit(dsl_pkg::CMD_HOST_RESET, dsl_pkg::KEY_RESET) && in_run) begin
      host_rst_flag_q <= 1'b1;
      host_rst_q      <= 1'b1;
    end else begin
      if (reset_entry && !host_rst_q) begin
        host_rst_flag_q <= 1'b0;
      end
      host_rst_q <= 1'b0;
    end
  end

  // restart decision: off_reached with wake when unblocked, any wake rise when blocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q  <= 1'b0;
      start_q <= 1'b0;
    end else begin
      wake_q  <= wake;
      start_q <= auto_block_q ? (wake && !wake_q) : (off_reached && wake);
    end
  end

  assign status_main = {device_state, 1'b0, auto_block_q, cfg_guard_q,
                        bist_guard_q, ctrl_guard_q};
  assign status_secondary = {1'b0, diag_hold_q, safe_timeout_off, host_rst_flag_q,
                             sync_clk_ok, host_err_in, wake_latched, wake};

  // status reads have no side effect and no write path exists
  always_comb begin
    rsp_data_d = 8'h00;
    if (take) begin
      if (link.cmd_code == dsl_pkg::CMD_READ_STATUS_MAIN) begin
        rsp_data_d = status_main;
      end else if (link.cmd_code == dsl_pkg::CMD_READ_STATUS_SECONDARY) begin
        rsp_data_d = status_secondary;
      end
    end
  end

  // every command is answered, with zeros while in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
    end else begin
      rsp_valid_q <= link.cmd_valid;
      rsp_data_q  <= rsp_data_d;
    end
  end

  assign link.rsp_valid         = rsp_valid_q;
  assign link.rsp_data          = rsp_data_q;
  assign auto_restart_block     = auto_block_q;
  assign config_write_guard     = cfg_guard_q;
  assign control_write_guard    = ctrl_guard_q;
  assign selftest_control_guard = bist_guard_q;
  assign diag_timer_hold        = diag_hold_q;
  assign start_request          = start_q;
  assign host_reset_request     = host_rst_q;
endmodule
`default_nettype wire

// [hdl/dsl_host.sv]
`default_nettype none
module dsl_host (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // command link
  dsl_link_if.host         link
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_WAIT = 2'b10
  } dsl_hstate_type;

  dsl_hstate_type state_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        cmd_valid_q;
  logic [7:0]  cmd_code_q;
  logic [7:0]  cmd_data_q;
  logic [7:0]  last_rsp_q;
  logic        access;
  logic        mapped;
  logic        start;

  // one wait state keeps pready registered
  assign access = psel && penable && !pready_q;
  assign mapped = (paddr == dsl_pkg::OFS_COMMAND) || (paddr == dsl_pkg::OFS_STATUS);
  // a command write while busy is dropped, never queued
  assign start  = access && pwrite && (paddr == dsl_pkg::OFS_COMMAND) &&
                  (state_q == HS_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access;
      pslverr_q <= access && !mapped;
      prdata_q  <= 32'h0000_0000;
      if (access && !pwrite && (paddr == dsl_pkg::OFS_STATUS)) begin
        prdata_q <= {23'h00_0000, state_q == HS_WAIT, last_rsp_q};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= HS_IDLE;
      cmd_valid_q <= 1'b0;
      cmd_code_q  <= 8'h00;
      cmd_data_q  <= 8'h00;
      last_rsp_q  <= 8'h00;
    end else begin
      cmd_valid_q <= 1'b0;
      unique case (state_q)
        HS_IDLE: begin
          if (start) begin
            // key bytes come from software as written
            cmd_code_q  <= pwdata[dsl_pkg::CMD_CODE_LSB +: 8];
            cmd_data_q  <= pwdata[7:0];
            cmd_valid_q <= 1'b1;
            state_q     <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (link.rsp_valid) begin
            last_rsp_q <= link.rsp_data;
            state_q    <= HS_IDLE;
          end
        end
      endcase
    end
  end

  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign prdata         = prdata_q;
  assign link.cmd_valid = cmd_valid_q;
  assign link.cmd_code  = cmd_code_q;
  assign link.cmd_data  = cmd_data_q;
endmodule
`default_nettype wire

// [hdl/dsl_link_if.sv]
`default_nettype none
interface dsl_link_if;
  logic       cmd_valid;
  logic [7:0] cmd_code;
  logic [7:0] cmd_data;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  modport dev  (input cmd_valid, cmd_code, cmd_data, output rsp_valid, rsp_data);
  modport host (output cmd_valid, cmd_code, cmd_data, input rsp_valid, rsp_data);
endinterface
`default_nettype wire

// [hdl/dsl_pkg.sv]
// Operation
// - state field bits 7:5, one-hot diag/active/safe
// - reset state: link ignored, answers all zero
// - restart block set 0xAA, cleared 0x55
// - restart block survives power-on reset only
// - regulator overvoltage forces restart block high
// - latch low autorestarts; high needs wake rise
// - config guard set by command, diag exit, selftest
// - config guard cleared by 0xAA, diag only
// - selftest guard as control guard, but set on any run-state exit
// - control guard set/cleared by control commands
// - second status readable, initialised on power-on
// - diag exit hold 0x55/0xAA, holds diag timer
// - host reset flag kept across reads
`default_nettype none
package dsl_pkg;
  // operating state codes
  localparam logic [2:0] ST_DIAG   = 3'h1;
  localparam logic [2:0] ST_ACTIVE = 3'h2;
  localparam logic [2:0] ST_SAFE   = 3'h4;
  // command codes on the link
  localparam logic [7:0] CMD_READ_STATUS_MAIN      = 8'h10;
  localparam logic [7:0] CMD_READ_STATUS_SECONDARY = 8'h11;
  localparam logic [7:0] CMD_BLOCK_AUTO_RESTART    = 8'h20;
  localparam logic [7:0] CMD_ALLOW_AUTO_RESTART    = 8'h21;
  localparam logic [7:0] CMD_GUARD_CONFIG          = 8'h30;
  localparam logic [7:0] CMD_UNGUARD_CONFIG        = 8'h31;
  localparam logic [7:0] CMD_GUARD_CONTROL         = 8'h32;
  localparam logic [7:0] CMD_UNGUARD_CONTROL       = 8'h33;
  localparam logic [7:0] CMD_HOLD_DIAG_EXIT        = 8'h40;
  localparam logic [7:0] CMD_RELEASE_DIAG_EXIT     = 8'h41;
  localparam logic [7:0] CMD_HOST_RESET            = 8'h50;
  // key bytes
  localparam logic [7:0] KEY_55    = 8'h55;
  localparam logic [7:0] KEY_AA    = 8'hAA;
  localparam logic [7:0] KEY_RESET = 8'h5A;
  // field positions, status main
  localparam int STATE_LSB        = 5;
  localparam int AUTO_BLOCK_BIT   = 3;
  localparam int CFG_GUARD_BIT    = 2;
  localparam int BIST_GUARD_BIT   = 1;
  localparam int CTRL_GUARD_BIT   = 0;
  // field positions, status secondary
  localparam int DIAG_HOLD_BIT    = 6;
  localparam int SAFE_TO_OFF_BIT  = 5;
  localparam int HOST_RST_BIT     = 4;
  localparam int SYNC_OK_BIT      = 3;
  localparam int HOST_ERR_BIT     = 2;
  localparam int WAKE_LATCH_BIT   = 1;
  localparam int WAKE_BIT         = 0;
  // reset values
  localparam logic RST_AUTO_BLOCK = 1'b0;
  localparam logic RST_GUARD      = 1'b1;
  localparam logic RST_DIAG_HOLD  = 1'b0;
  localparam logic RST_HOST_RST   = 1'b0;
  // controller register offsets (APB byte addresses) and bit positions
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam int CMD_CODE_LSB = 8;
  localparam int BUSY_BIT     = 8;
endpackage
`default_nettype wire

// [verification/device_state_lock_status_tb.sv]
`default_nettype none
module device_state_lock_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] device_state;
  logic in_rst, off_reached, lbist_done, reg_ov, wake, wake_l, host_err, sync_ok, sto_off;
  logic auto_blk, cfg_g, ctrl_g, bist_g, hold_o, start_req, rst_req, er, rst_entry;
  logic m_auto, m_cfg, m_bist, m_ctrl, m_hold, m_rst;
  logic [31:0] rv;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  logic [7:0] codes[8] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'h32, 8'h33, 8'h40, 8'h41};
  logic [2:0] sts[3] = '{3'h1, 3'h2, 3'h4};
  int error_cnt, n_tests, starts, rreqs;
  integer seed = 32'h1670;
  dsl_link_if link();
  dsl_device i_dsl_device (.pclk(pclk), .presetn(presetn), .power_on_reset_n(por_n),
    .link(link), .device_state(device_state), .in_reset_state(in_rst),
    .off_reached(off_reached), .reset_entry(rst_entry), .lbist_done(lbist_done),
    .regulator_ov(reg_ov), .wake(wake), .wake_latched(wake_l), .host_err_in(host_err),
    .sync_clk_ok(sync_ok), .safe_timeout_off(sto_off), .auto_restart_block(auto_blk),
    .config_write_guard(cfg_g), .control_write_guard(ctrl_g),
    .selftest_control_guard(bist_g), .diag_timer_hold(hold_o),
    .start_request(start_req), .host_reset_request(rst_req));
  dsl_host i_dsl_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .link(link));
  dsl_link_assertions i_dsl_link_assertions (.pclk(pclk), .presetn(presetn),
    .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .cmd_data(link.cmd_data),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));
  task automatic fail(input string m);
    $display("mismatch at %0t: %s", $time, m);
    error_cnt++;
  endtask
  task automatic cmp(input logic [7:0] g, x, input string m);
    n_tests++;
    if (g !== x) fail(m);
  endtask
  task automatic stop_test();
    $display("comparisons %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // pready, prdata and pslverr are read as they stood at the edge itself
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin fail("apb hang"); stop_test(); end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic [7:0] c, d, input logic [8:0] x);
    int k;
    exp_q.push_back(x);
    apb(1'b1, dsl_pkg::OFS_COMMAND, {16'h0000, c, d});
    k = 0;
    do begin apb(1'b0, dsl_pkg::OFS_STATUS, 32'h0000_0000); k++; end
    while (r[dsl_pkg::BUSY_BIT] !== 1'b0 && k < 20);
    if (r[dsl_pkg::BUSY_BIT] !== 1'b0) begin fail("busy stuck"); stop_test(); end
  endtask
  // bench copy of the latches and flags
  task automatic op(input logic [7:0] c, d);
    logic hit;
    hit = !in_rst && (d == ((c == 8'h50) ? 8'h5A :
      ((c inside {8'h20, 8'h31, 8'h33, 8'h41}) ? 8'hAA : 8'h55)));
    if (hit) case (c)
      8'h20: m_auto = 1'b1;
      8'h21: m_auto = reg_ov;
      8'h30: if (device_state == 3'h1) m_cfg = 1'b1;
      8'h31: if (device_state == 3'h1) m_cfg = 1'b0;
      8'h32, 8'h33: {m_ctrl, m_bist} = {2{c == 8'h32}};
      8'h50: m_rst = 1'b1;
      default: m_hold = c == 8'h40;
    endcase
    // keyed commands answer zero whether or not they took effect
    send(c, d, {1'b1, 8'h00});
  endtask
  task automatic chk();
    send(8'h10, 8'h00, {1'b1, in_rst ? 8'h00 : {device_state, 1'b0, m_auto, m_cfg, m_bist,
      m_ctrl}});
    send(8'h11, 8'h00, {1'b1, in_rst ? 8'h00 : {1'b0, m_hold, sto_off, m_rst, sync_ok,
      host_err, wake_l, wake}});
    cmp({3'h0, auto_blk, cfg_g, bist_g, ctrl_g, hold_o},
      {3'h0, m_auto, m_cfg, m_bist, m_ctrl, m_hold}, "guard outputs");
  endtask
  task automatic go(input logic [2:0] s);
    if (device_state == 3'h1 && s != 3'h1) {m_cfg, m_ctrl} = 2'b11;
    if (s != device_state) m_bist = 1'b1;
    @(posedge pclk);
    device_state <= s;
    repeat (2) @(posedge pclk);
  endtask
  task automatic rst(input bit full);
    @(posedge pclk);
    if (full) presetn <= 1'b0;
    else por_n <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1; por_n <= 1'b1;
    {m_cfg, m_bist, m_ctrl, m_hold, m_rst} = 5'b11100;
    if (full) m_auto = 1'b0;
  endtask
  // which: 0 self-test done, 1 off reached, 2 wake, 3 reset entry
  task automatic pulse(input int which);
    @(posedge pclk);
    if (which == 0) lbist_done <= 1'b1;
    else if (which == 1) off_reached <= 1'b1;
    else if (which == 2) wake <= 1'b1;
    else rst_entry <= 1'b1;
    @(posedge pclk);
    lbist_done <= 1'b0;
    off_reached <= 1'b0;
    rst_entry <= 1'b0;
    if (which == 2) wake <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  always @(negedge pclk) begin
    if (start_req === 1'b1) starts++;
    if (rst_req === 1'b1) rreqs++;
    if (link.rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) fail("response not expected");
      else begin
        e = exp_q.pop_front();
        if (e[8]) cmp(link.rsp_data, e[7:0], "link response");
      end
    end
  end
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, in_rst, off_reached, rst_entry} = '0;
    {lbist_done, reg_ov, wake, wake_l, host_err, sync_ok, sto_off, error_cnt, n_tests} = '0;
    por_n = 1'b1;
    device_state = 3'h1;
    rst(1);
    chk();
    apb(1'b0, 8'h08, 32'h0000_0000);
    cmp({7'h00, er}, 8'h01, "unmapped error");
    cmp(r[7:0], 8'h00, "unmapped data");
    apb(1'b1, dsl_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    cmp({7'h00, er}, 8'h00, "status write error");
    send(8'h7E, 8'h00, {1'b1, 8'h00});
    chk();
    for (int i = 0; i < 60; i++) begin
      rv = $random(seed);
      if (rv[3:2] == 2'b00) go(sts[rv[5:4] % 3]);
      {wake, wake_l, host_err, sync_ok, sto_off} <= rv[12:8];
      op(codes[rv[22:20]], rv[17] ? rv[31:24] : (rv[16] ? 8'hAA : 8'h55));
      if (rv[6]) chk();
    end
    in_rst <= 1'b1;
    // let the reset level land before the model reads it
    @(posedge pclk);
    op(8'h33, 8'hAA);
    chk();
    in_rst <= 1'b0;
    pulse(0);
    {m_cfg, m_ctrl, m_bist} = 3'b111;
    reg_ov <= 1'b1;
    @(posedge pclk);
    op(8'h21, 8'h55);
    chk();
    reg_ov <= 1'b0;
    op(8'h33, 8'hAA);
    op(8'h40, 8'h55);
    op(8'h50, 8'h5A);
    chk();
    chk();
    cmp(8'(rreqs), 8'h01, "host reset request");
    pulse(3);
    m_rst = 1'b0;
    chk();
    rst(0);
    chk();
    rst(1);
    chk();
    wake <= 1'b1;
    starts = 0;
    pulse(1);
    cmp(8'(starts), 8'h01, "restart with latch clear");
    op(8'h20, 8'hAA);
    pulse(1);
    pulse(2);
    pulse(2);
    cmp(8'(starts), 8'h02, "restart with latch set");
    if (exp_q.size() != 0) fail("responses missing");
    stop_test();
  end
  initial begin
    #2_000_000;
    fail("run too long");
    stop_test();
  end
endmodule
`default_nettype wire

// [verification/dsl_link_assertions.sv]
`default_nettype none
module dsl_link_assertions (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // link
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_data,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] key;
  // key byte of each keyed code except 0x50, zero where none is checked
  always_comb begin
    case (cmd_code)
      8'h20, 8'h31, 8'h33, 8'h41: key = 8'hAA;
      8'h21, 8'h30, 8'h32, 8'h40: key = 8'h55;
      default: key = 8'h00;
    endcase
  end
  property p_answer; cmd_valid |=> rsp_valid; endproperty
  a_answer: assert property (p_answer) else $error("command not answered");
  property p_cause; rsp_valid |-> $past(cmd_valid); endproperty
  a_cause: assert property (p_cause) else $error("response without command");
  property p_spacing; cmd_valid |=> !cmd_valid [*2]; endproperty
  a_spacing: assert property (p_spacing) else $error("commands too close");
  property p_hold; cmd_valid |=> $stable(cmd_code) && $stable(cmd_data); endproperty
  a_hold: assert property (p_hold) else $error("command fields moved");
  property p_key; cmd_valid && key != 8'h00 && cmd_data != key |=> rsp_data == 8'h00; endproperty
  a_key: assert property (p_key) else $error("wrong key answered");
  property p_unknown;
    cmd_valid && !(cmd_code inside {[8'h10:8'h11], [8'h20:8'h21], [8'h30:8'h33],
      [8'h40:8'h41], 8'h50}) |=> rsp_data == 8'h00;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown code answered");
  property p_state; cmd_valid && cmd_code == 8'h10 |=>
    rsp_data[7:5] inside {3'h0, 3'h1, 3'h2, 3'h4} && !rsp_data[4]; endproperty
  a_state: assert property (p_state) else $error("bad state field");
  property p_second; cmd_valid && cmd_code == 8'h11 |=> !rsp_data[7]; endproperty
  a_second: assert property (p_second) else $error("reserved bit set");
  c_read: cover property (cmd_valid && cmd_code == 8'h10);
  c_badkey: cover property (cmd_valid && key != 8'h00 && cmd_data != key);
  c_block: cover property (cmd_valid && cmd_code == 8'h20 && cmd_data == 8'hAA);
endmodule
`default_nettype wire
